// *** core/remote_local_events.sv ***
// front-panel remote/local control, key lockout and event-code classification queue
// assumes bus decode elsewhere delivers one-cycle pulses for listen addressing, go-to-local
// and local lockout, and that all inputs are synchronous to sys_clk
`timescale 1ns/1ps

module remote_local_events
    import remote_local_pkg::*;
#(
    parameter int BLINK_CYC = BLINK_HALF_CYC,
    parameter int DEPTH = QUEUE_DEPTH,
    parameter int KEYS = NUM_KEYS
) (
    input wire logic sys_clk, // system clock, 250 MHz
    input wire logic nrst, // asynchronous reset, active low
    input wire logic host_control_grant_line, // remote-enable line level from the bus
    input wire logic listen_addr, // pulse: addressed as listener
    input wire logic go_local_cmd, // pulse: go-to-local bus command
    input wire logic lockout_cmd, // pulse: local lockout bus command
    input wire logic local_key, // pulse: local key pressed
    input wire logic [KEYS-1:0] panel_keys, // pulses: other front-panel keys
    input wire logic user_msg_shown, // level: display holds a user message
    input wire logic evt_valid, // pulse: new message code offered
    input wire logic signed [CODE_W-1:0] evt_code, // message code
    input wire logic queue_pop, // pulse: controller reads the oldest entry
    input wire logic summary_clr, // pulse: clear the sticky summary bits
    input wire logic [2:0] srq_enable, // enables for error, system error, status summaries
    output logic remote_r, // level: device in remote state
    output logic lockout_r, // level: local lockout in effect
    output logic remote_ind_r, // level: blinking remote indicator
    output logic [KEYS-1:0] keys_out_r, // pulses: keys passed to the panel logic
    output logic display_restore_r, // pulse: return display to normal
    output logic evt_reject_r, // pulse: offered code is not a known message
    output logic signed [CODE_W-1:0] head_code_r, // oldest queued code
    output event_class_t head_class_r, // class of the oldest queued code
    output logic queue_avail_r, // level: queue holds at least one entry
    output logic [3:0] queue_count_r, // number of queued entries
    output logic err_sum_r, // sticky: error event seen
    output logic sys_sum_r, // sticky: system error event seen
    output logic stat_sum_r, // sticky: status event seen
    output logic srq_r // level: service request
);

    // ****************************************
    // elaboration checks
    // ****************************************
    if (DEPTH < 2 || DEPTH > 15) begin : g_depth_chk
        $error("queue depth must be 2 to 15");
    end
    if (BLINK_CYC < 1) begin : g_blink_chk
        $error("blink count must be at least one");
    end

    // ****************************************
    // code classification
    // ****************************************
    function automatic event_class_t classify(input logic signed [CODE_W-1:0] c);
        event_class_t k;
        k = no_event_class;
        unique case (c)
            -11'sd440, -11'sd430, -11'sd420, -11'sd410: k = error_event_class;
            -11'sd363, -11'sd350: k = system_error_class;
            -11'sd330, -11'sd314, -11'sd315: k = error_event_class;
            -11'sd260, -11'sd241, -11'sd230, -11'sd225, -11'sd224, -11'sd223,
            -11'sd222, -11'sd221, -11'sd220, -11'sd200: k = error_event_class;
            -11'sd178, -11'sd171, -11'sd170, -11'sd161, -11'sd160, -11'sd158,
            -11'sd154, -11'sd151, -11'sd150, -11'sd148, -11'sd144, -11'sd141,
            -11'sd140, -11'sd124, -11'sd123, -11'sd121, -11'sd120, -11'sd114,
            -11'sd113, -11'sd112, -11'sd111, -11'sd110, -11'sd109, -11'sd108,
            -11'sd105, -11'sd104, -11'sd103, -11'sd102, -11'sd101,
            -11'sd100: k = error_event_class;
            11'sd0, 11'sd101, 11'sd301, 11'sd302, 11'sd306, 11'sd310: k = status_event_class;
            11'sd320, 11'sd321, 11'sd322, 11'sd323: k = status_event_class;
            11'sd404, 11'sd405, 11'sd406, 11'sd407, 11'sd409, 11'sd410,
            11'sd411, 11'sd412, 11'sd413, 11'sd438, 11'sd440: k = error_event_class;
            11'sd500, 11'sd510, 11'sd511, 11'sd512, 11'sd514, 11'sd515,
            11'sd522: k = error_event_class;
            11'sd610: k = status_event_class;
            11'sd900: k = error_event_class;
            default: k = no_event_class;
        endcase
        return k;
    endfunction

    // ****************************************
    // remote/local state
    // ****************************************
    panel_state_t state_r;
    logic local_ok;

    // the local key only counts when lockout is not in effect
    assign local_ok = local_key && !lockout_r;

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state_r <= ST_LOCAL;
        end else begin
            unique case (state_r)
                ST_LOCAL: begin
                    // remote-enable alone is not enough; the listen address must arrive with it
                    if (listen_addr && host_control_grant_line && !go_local_cmd) begin
                        state_r <= ST_REMOTE;
                    end
                end
                ST_REMOTE: begin
                    if (go_local_cmd || !host_control_grant_line) begin
                        state_r <= ST_LOCAL;
                    end else if (local_ok) begin
                        state_r <= ST_LOCAL;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            remote_r <= 1'b0;
        end else begin
            remote_r <= (state_r == ST_REMOTE);
        end
    end

    // lockout survives until go-to-local or reset; dropping remote-enable also ends it
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            lockout_r <= RESET_LOCKOUT;
        end else if (go_local_cmd || !host_control_grant_line) begin
            lockout_r <= 1'b0;
        end else if (lockout_cmd) begin
            lockout_r <= 1'b1;
        end
    end

    // ****************************************
    // indicator blink
    // ****************************************
    logic [31:0] blink_cnt_r;
    logic blink_phase_r;

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            blink_cnt_r <= 32'h0000_0000;
            blink_phase_r <= RESET_BLINK;
        end else if (state_r != ST_REMOTE) begin
            // restart so the block always appears lit first on entry
            blink_cnt_r <= 32'h0000_0000;
            blink_phase_r <= 1'b1;
        end else if (blink_cnt_r == 32'(BLINK_CYC - 1)) begin
            blink_cnt_r <= 32'h0000_0000;
            blink_phase_r <= !blink_phase_r;
        end else begin
            blink_cnt_r <= blink_cnt_r + 32'h0000_0001;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            remote_ind_r <= 1'b0;
        end else begin
            remote_ind_r <= (state_r == ST_REMOTE) && blink_phase_r && !local_ok;
        end
    end

    // ****************************************
    // key gating
    // ****************************************
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            keys_out_r <= '0;
            display_restore_r <= 1'b0;
        end else begin
            keys_out_r <= (state_r == ST_REMOTE) ? '0 : panel_keys;
            display_restore_r <= (state_r == ST_REMOTE) && local_ok && user_msg_shown;
        end
    end

    // ****************************************
    // message queue
    // ****************************************
    localparam int PW = $clog2(DEPTH);
    logic signed [CODE_W-1:0] code_mem [DEPTH];
    event_class_t class_mem [DEPTH];
    logic [PW-1:0] wr_ptr_r;
    logic [PW-1:0] rd_ptr_r;
    logic [3:0] count_r;
    event_class_t in_class;
    logic do_pop;
    logic do_push;
    logic full;

    function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
        return (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
    endfunction

    assign in_class = classify(evt_code);
    assign full = (count_r == 4'(DEPTH));
    assign do_pop = queue_pop && (count_r != 4'h0);
    assign do_push = evt_valid && (in_class != no_event_class);

    // when full, the newest slot is overwritten by the overflow code instead of losing order
    always_ff @(posedge sys_clk) begin
        if (do_push && !(full && !do_pop)) begin
            code_mem[wr_ptr_r] <= evt_code;
            class_mem[wr_ptr_r] <= in_class;
        end else if (do_push) begin
            code_mem[wr_ptr_r == '0 ? PW'(DEPTH - 1) : PW'(wr_ptr_r - 1'b1)] <= CODE_QUEUE_OVERFLOW;
            class_mem[wr_ptr_r == '0 ? PW'(DEPTH - 1) : PW'(wr_ptr_r - 1'b1)] <= system_error_class;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= 4'h0;
        end else begin
            if (do_push && !(full && !do_pop)) begin
                wr_ptr_r <= ptr_inc(wr_ptr_r);
            end
            if (do_pop) begin
                rd_ptr_r <= ptr_inc(rd_ptr_r);
            end
            if ((do_push && !full) && !do_pop) begin
                count_r <= count_r + 4'h1;
            end else if (do_pop && !do_push) begin
                count_r <= count_r - 4'h1;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            head_code_r <= '0;
            head_class_r <= no_event_class;
            queue_avail_r <= 1'b0;
            queue_count_r <= 4'h0;
            evt_reject_r <= 1'b0;
        end else begin
            head_code_r <= (count_r != 4'h0) ? code_mem[rd_ptr_r] : '0;
            head_class_r <= (count_r != 4'h0) ? class_mem[rd_ptr_r] : no_event_class;
            queue_avail_r <= (count_r != 4'h0);
            queue_count_r <= count_r;
            evt_reject_r <= evt_valid && (in_class == no_event_class);
        end
    end

    // ****************************************
    // class summaries and service request
    // ****************************************
    // a new event in the clearing cycle wins over the clear
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            err_sum_r <= 1'b0;
            sys_sum_r <= 1'b0;
            stat_sum_r <= 1'b0;
        end else begin
            err_sum_r <= (do_push && in_class == error_event_class) || (err_sum_r && !summary_clr);
            sys_sum_r <= (do_push && (in_class == system_error_class || (full && !do_pop)))
                         || (sys_sum_r && !summary_clr);
            stat_sum_r <= (do_push && in_class == status_event_class) || (stat_sum_r && !summary_clr);
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            srq_r <= 1'b0;
        end else begin
            srq_r <= |({stat_sum_r, sys_sum_r, err_sum_r} & srq_enable);
        end
    end

    // ****************************************
    // checks
    // ****************************************
    ren_only_stays_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        (state_r == ST_LOCAL && !listen_addr) |=> state_r == ST_LOCAL)
        else $error("remote entered without listen addressing");
    remote_entry_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        (state_r == ST_LOCAL && listen_addr && host_control_grant_line && !go_local_cmd) |=> ##1 remote_r)
        else $error("remote not entered after listen with remote enable");
    indicator_remote_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        remote_ind_r |-> $past(state_r) == ST_REMOTE)
        else $error("indicator lit outside remote");
    keys_locked_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        (state_r == ST_REMOTE) |=> keys_out_r == '0)
        else $error("key passed while remote");
    local_key_exit_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        (state_r == ST_REMOTE && local_key && !lockout_r) |=> state_r == ST_LOCAL ##1 !remote_r)
        else $error("local key did not leave remote");
    lockout_hold_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        (state_r == ST_REMOTE && lockout_r && !go_local_cmd && host_control_grant_line)
        |=> state_r == ST_REMOTE)
        else $error("remote left under lockout");
    go_local_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        go_local_cmd |=> !lockout_r && state_r == ST_LOCAL)
        else $error("go-to-local did not cancel");
    queue_bound_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        count_r <= 4'(DEPTH))
        else $error("queue beyond depth");
    overflow_class_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        (do_push && full && !do_pop) |=> sys_sum_r)
        else $error("overflow not flagged as system error");
    error_class_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        (evt_valid && evt_code == -11'sd410) |=> err_sum_r && !evt_reject_r)
        else $error("query fault not an error event");
    status_class_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        (evt_valid && evt_code == 11'sd323) |=> stat_sum_r)
        else $error("shutdown code not a status event");
    srq_follow_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        (err_sum_r && srq_enable[0]) |=> srq_r)
        else $error("service request missing");

endmodule // remote_local_events

// *** include/remote_local_pkg.sv ***
// constants and types for the remote/local front-panel block and its event-code queue
// assumes one 250 MHz system clock; codes are signed decimal message numbers
package remote_local_pkg;

    // ****************************************
    // clock and timing
    // ****************************************
    localparam int CLK_PERIOD_PS = 4000;
    localparam int BLINK_HALF_MS = 250;
    localparam longint BLINK_HALF_CYC_L = (longint'(BLINK_HALF_MS) * 64'd1000000000) / CLK_PERIOD_PS;
    localparam int BLINK_HALF_CYC = int'(BLINK_HALF_CYC_L);

    // ****************************************
    // queue and code sizes
    // ****************************************
    localparam int QUEUE_DEPTH = 10;
    localparam int CODE_W = 11;
    localparam int NUM_KEYS = 8;

    // ****************************************
    // event classes
    // ****************************************
    typedef enum logic [1:0] {
        no_event_class = 2'b00,
        error_event_class = 2'b01,
        status_event_class = 2'b10,
        system_error_class = 2'b11
    } event_class_t;

    // ****************************************
    // remote/local state
    // ****************************************
    typedef enum logic [0:0] {
        ST_LOCAL = 1'b0,
        ST_REMOTE = 1'b1
    } panel_state_t;

    // reset values
    localparam logic RESET_LOCKOUT = 1'b0;
    localparam logic RESET_BLINK = 1'b0;

    // code written in place of the newest entry when the queue overflows
    localparam logic signed [CODE_W-1:0] CODE_QUEUE_OVERFLOW = -11'sd350;

endpackage

// *** tb/panel_partner.sv ***
// behavioural bus controller and front-panel keys facing the remote/local block
// assumes the testbench calls its tasks; all drives land on the rising edge of sys_clk
`timescale 1ns/1ps

module panel_partner
    import remote_local_pkg::*;
#(
    parameter int KEYS = NUM_KEYS
) (
    input wire logic sys_clk, // system clock
    output logic host_control_grant_line, // remote-enable line level
    output logic listen_addr, // addressed-to-listen pulse
    output logic go_local_cmd, // go-to-local pulse
    output logic lockout_cmd, // local lockout pulse
    output logic local_key, // local key pulse
    output logic [KEYS-1:0] panel_keys // other key pulses
);
    initial begin
        host_control_grant_line = 1'b0;
        listen_addr = 1'b0;
        go_local_cmd = 1'b0;
        lockout_cmd = 1'b0;
        local_key = 1'b0;
        panel_keys = '0;
    end

    // ****************************************
    // controller and key actions
    // ****************************************
    // remote-enable is a level the controller holds across addressing
    task automatic set_ren(input logic v);
        @(posedge sys_clk);
        host_control_grant_line <= v;
    endtask

    // one-cycle strobe: bit0 listen, bit1 go-to-local, bit2 lockout, bit3 local key
    task automatic strobe(input logic [3:0] sel, input logic [KEYS-1:0] keys);
        @(posedge sys_clk);
        listen_addr <= sel[0];
        go_local_cmd <= sel[1];
        lockout_cmd <= sel[2];
        local_key <= sel[3];
        panel_keys <= keys;
        @(posedge sys_clk);
        {listen_addr, go_local_cmd, lockout_cmd, local_key} <= 4'h0;
        panel_keys <= '0;
    endtask
endmodule // panel_partner

// *** tb/remote_local_events_test.sv ***
// self-checking bench for the remote/local block and its event-code queue
// assumes the partner model drives the bus and key inputs; blink shortened to 4 cycles
`timescale 1ns/1ps

module remote_local_events_test;
    import remote_local_pkg::*;

    // ****************************************
    // signals
    // ****************************************
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic host_control_grant_line, listen_addr, go_local_cmd, lockout_cmd, local_key;
    logic [NUM_KEYS-1:0] panel_keys, keys_out_r, acc_keys;
    logic user_msg_shown = 1'b0, evt_valid = 1'b0, queue_pop = 1'b0, summary_clr = 1'b0;
    logic signed [CODE_W-1:0] evt_code = '0, head_code_r;
    logic [2:0] srq_enable = 3'h0;
    logic remote_r, lockout_r, remote_ind_r, display_restore_r, evt_reject_r, queue_avail_r;
    logic err_sum_r, sys_sum_r, stat_sum_r, srq_r, acc_rest, acc_rej;
    event_class_t head_class_r;
    logic [3:0] queue_count_r;
    int bad_count = 0, cmp_count = 0;
    logic signed [CODE_W-1:0] codes [20] = '{-410, -440, -363, -350, -200, -222, -260, -100, -178, 0,
        101, 310, 320, 323, 404, 440, 510, 522, 610, 900};
    event_class_t cls [20] = '{error_event_class, error_event_class, system_error_class,
        system_error_class, error_event_class, error_event_class, error_event_class, error_event_class,
        error_event_class, status_event_class, status_event_class, status_event_class, status_event_class,
        status_event_class, error_event_class, error_event_class, error_event_class, error_event_class,
        status_event_class, error_event_class};

    always #2 sys_clk = ~sys_clk;

    panel_partner #(.KEYS(NUM_KEYS)) ptn (.sys_clk, .host_control_grant_line, .listen_addr, .go_local_cmd,
        .lockout_cmd, .local_key, .panel_keys);

    remote_local_events #(.BLINK_CYC(4), .DEPTH(QUEUE_DEPTH), .KEYS(NUM_KEYS)) DUT (.sys_clk, .nrst,
        .host_control_grant_line, .listen_addr, .go_local_cmd, .lockout_cmd, .local_key, .panel_keys,
        .user_msg_shown, .evt_valid, .evt_code, .queue_pop, .summary_clr, .srq_enable, .remote_r, .lockout_r,
        .remote_ind_r, .keys_out_r, .display_restore_r, .evt_reject_r, .head_code_r, .head_class_r,
        .queue_avail_r, .queue_count_r, .err_sum_r, .sys_sum_r, .stat_sum_r, .srq_r);

    // ****************************************
    // helpers
    // ****************************************
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    // pulse outputs last one cycle, so they are gathered over a window
    task automatic watch(input int n);
        acc_keys = '0;
        acc_rest = 1'b0;
        acc_rej = 1'b0;
        repeat (n) begin
            #1;
            acc_keys |= keys_out_r;
            acc_rest |= display_restore_r;
            acc_rej |= evt_reject_r;
            @(posedge sys_clk);
        end
    endtask

    task automatic strobe_tb(input int which, input logic signed [CODE_W-1:0] c);
        @(posedge sys_clk);
        evt_valid <= (which == 0);
        evt_code <= c;
        queue_pop <= (which == 1);
        summary_clr <= (which == 2);
        @(posedge sys_clk);
        {evt_valid, queue_pop, summary_clr} <= 3'h0;
    endtask

    task automatic enter_remote();
        ptn.set_ren(1'b1);
        ptn.strobe(4'h1, '0);
        cyc(3);
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_entry();
        ptn.strobe(4'h1, '0);
        cyc(4);
        chk(16'(remote_r), 16'h0000);
        ptn.set_ren(1'b1);
        cyc(5);
        chk(16'(remote_r), 16'h0000);
        ptn.strobe(4'h1, '0);
        cyc(3);
        chk(16'(remote_r), 16'h0001);
        chk(16'(remote_ind_r), 16'h0001);
    endtask

    task automatic t_blink();
        int lit;
        lit = 0;
        repeat (16) begin
            lit += int'(remote_ind_r);
            cyc(1);
        end
        chk(16'(lit), 16'h0008);
    endtask

    task automatic t_keys();
        ptn.strobe(4'h0, 8'hA5);
        watch(3);
        chk(16'(acc_keys), 16'h0000);
        user_msg_shown <= 1'b1;
        ptn.strobe(4'h8, '0);
        watch(4);
        chk(16'(acc_rest), 16'h0001);
        chk(16'({remote_r, remote_ind_r}), 16'h0000);
        user_msg_shown <= 1'b0;
        ptn.strobe(4'h0, 8'h5A);
        watch(3);
        chk(16'(acc_keys), 16'h005A);
    endtask

    task automatic t_lockout();
        enter_remote();
        ptn.strobe(4'h4, '0);
        cyc(3);
        chk(16'(lockout_r), 16'h0001);
        ptn.strobe(4'h8, '0);
        cyc(4);
        chk(16'(remote_r), 16'h0001);
        ptn.strobe(4'h2, '0);
        cyc(4);
        chk(16'({remote_r, lockout_r}), 16'h0000);
    endtask

    // a power cycle in mid-run must drop lockout even with remote-enable still held
    task automatic t_power();
        enter_remote();
        ptn.strobe(4'h4, '0);
        cyc(2);
        chk(16'({remote_r, lockout_r}), 16'h0003);
        @(posedge sys_clk);
        nrst <= 1'b0;
        repeat (4) @(posedge sys_clk);
        nrst <= 1'b1;
        cyc(2);
        chk(16'({remote_r, lockout_r, queue_count_r}), 16'h0000);
    endtask

    task automatic t_classes();
        logic [2:0] m;
        for (int i = 0; i < 20; i++) begin
            m = {cls[i] == status_event_class, cls[i] == system_error_class, cls[i] == error_event_class};
            @(posedge sys_clk);
            srq_enable <= m;
            strobe_tb(2, '0);
            strobe_tb(0, codes[i]);
            cyc(3);
            chk(16'(head_code_r), 16'(codes[i]));
            chk(16'(head_class_r), 16'(cls[i]));
            chk(16'({stat_sum_r, sys_sum_r, err_sum_r}), 16'(m));
            chk(16'(srq_r), 16'h0001);
            @(posedge sys_clk);
            srq_enable <= ~m;
            strobe_tb(1, '0);
            cyc(3);
            chk(16'({srq_r, queue_avail_r, queue_count_r}), 16'h0000);
        end
        strobe_tb(0, 11'sd999);
        watch(4);
        chk(16'({acc_rej, queue_count_r}), 16'h0010);
    endtask

    task automatic t_overflow();
        strobe_tb(2, '0);
        for (int i = 0; i <= QUEUE_DEPTH; i++) begin
            @(posedge sys_clk);
            evt_valid <= 1'b1;
            evt_code <= codes[i + 4];
        end
        @(posedge sys_clk);
        evt_valid <= 1'b0;
        cyc(3);
        chk(16'({sys_sum_r, queue_count_r}), 16'(5'h10 + QUEUE_DEPTH));
        // the newest entry is replaced by the overflow code, older ones keep their order
        for (int i = 0; i < QUEUE_DEPTH; i++) begin
            chk(16'(head_code_r), (i == QUEUE_DEPTH - 1) ? 16'(CODE_QUEUE_OVERFLOW) : 16'(codes[i + 4]));
            strobe_tb(1, '0);
            cyc(3);
        end
        chk(16'(queue_avail_r), 16'h0000);
    endtask

    // ****************************************
    // sequence and verdict
    // ****************************************
    task automatic report_and_stop();
        $display("TB: counts cmp=%0d bad=%0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (4) @(posedge sys_clk);
        nrst <= 1'b1;
        cyc(2);
        chk(16'({remote_r, lockout_r, queue_count_r}), 16'h0000);
        t_entry();
        t_blink();
        t_keys();
        t_lockout();
        t_power();
        t_classes();
        t_overflow();
        report_and_stop();
    end

    // whole run needs well under 2000 cycles
    initial begin
        #40000;
        bad_count++;
        report_and_stop();
    end
endmodule // remote_local_events_test
